// ### rtl/rff_pkg.sv
// Purpose: Shared constants, types and helpers for the rotate/fill file datapath
// Assumes: 8-bit file registers, 4-bit bank number, 16-bit instruction words
// Notes: Opcode and access-bank split values are named here once; the core's assertions repeat the fill opcode and the split as literals

package rff_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 8; // File register width
	localparam int ADDR_W = 8; // File address field width
	localparam int BANK_W = 4; // Bank number width
	localparam int FULL_ADDR_W = BANK_W + ADDR_W; // Bank plus offset

	// ----------------------------------------------------------------
	// Encodings and values
	// ----------------------------------------------------------------
	localparam logic [6:0] FILL_OPC = 7'h34; // Upper seven bits 0110 100
	localparam logic [5:0] ROT_OPC = 6'h10; // Upper six bits 0100 00
	localparam logic [DATA_W-1:0] FILL_VALUE = 8'hFF; // Fill pattern
	localparam logic [ADDR_W-1:0] ACC_SPLIT = 8'h80; // Access bank low/high split
	localparam logic [BANK_W-1:0] ACC_LO_BANK = 4'h0; // Bank of low access half
	localparam logic [BANK_W-1:0] ACC_HI_BANK = 4'hF; // Bank of high access half
	localparam logic [DATA_W-1:0] W_RESET = 8'h00; // Working register after reset
	localparam logic [FULL_ADDR_W-1:0] ADDR_RESET = 12'h000; // Address bus after reset
	localparam int PHASES = 4; // Phases per instruction cycle

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		RFF_Q1 = 4'b0001, // Decode
		RFF_Q2 = 4'b0010, // Read file register
		RFF_Q3 = 4'b0100, // Process data
		RFF_Q4 = 4'b1000 // Write destination
	} rff_phase_t;

	typedef enum logic [2:0] {
		RFF_OP_NONE = 3'b001, // Not one of ours
		RFF_OP_ROT = 3'b010, // Rotate right, carry untouched
		RFF_OP_FILL = 3'b100 // Fill with ones
	} rff_op_t;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Classify an instruction word
	function automatic rff_op_t rff_decode(input logic [15:0] word);
		rff_op_t op;
		op = RFF_OP_NONE;
		if (word[15:9] == FILL_OPC) begin
			op = RFF_OP_FILL;
		end else if (word[15:10] == ROT_OPC) begin
			op = RFF_OP_ROT;
		end
		return op;
	endfunction : rff_decode

	// Full data address from bank-select bit, offset and bank value
	function automatic logic [FULL_ADDR_W-1:0] rff_eff_addr(input logic bank_sel,
		input logic [ADDR_W-1:0] f, input logic [BANK_W-1:0] bank);
		logic [BANK_W-1:0] b;
		b = bank;
		if (!bank_sel) begin
			b = (f < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK;
		end
		return {b, f};
	endfunction : rff_eff_addr

endpackage : rff_pkg

// ### rtl/rff_alu_if.sv
// Purpose: Carrier between the sequencer and the rotate/fill data unit
// Assumes: Purely combinational exchange on the core clock
// Notes: The core supplies operation and operand, the unit returns result

`timescale 1ns/1ps
`default_nettype none

interface rff_alu_if;
	import rff_pkg::*;
	rff_op_t op; // Operation in flight
	logic [DATA_W-1:0] src; // Operand read from the file register
	logic [DATA_W-1:0] result; // Computed value
	logic status_we; // Request to update status flags

	modport core (output op, output src, input result, input status_we);
	modport alu (input op, input src, output result, output status_we);
endinterface : rff_alu_if

`default_nettype wire

// ### rtl/rff_alu.sv
// Purpose: Data unit computing rotate-right and fill results
// Assumes: Operand already latched by the core during the read phase
// Notes: Combinational; the core registers its outputs in the process phase

`timescale 1ns/1ps
`default_nettype none

module rff_alu
	import rff_pkg::*;
(
	rff_alu_if.alu bus // Operation in, result out
);

	// ----------------------------------------------------------------
	// Result and flag request
	// ----------------------------------------------------------------
	// Neither operation touches the flags, carry included
	always_comb begin
		bus.status_we = 1'b0;
		case (bus.op)
			RFF_OP_ROT: begin
				bus.result = {bus.src[0], bus.src[DATA_W-1:1]};
			end
			RFF_OP_FILL: begin
				bus.result = FILL_VALUE;
			end
			default: begin
				bus.result = bus.src; // Harmless pass-through
			end
		endcase
	end

endmodule : rff_alu

`default_nettype wire

// ### rtl/rff_core.sv
// Purpose: Four-phase execution of the rotate-right and fill file instructions
// Assumes: File memory answers a read combinationally within one clock
// Notes: One phase per clock; each instruction takes four clocks

`timescale 1ns/1ps
`default_nettype none

module rff_core
	import rff_pkg::*;
(
	input wire logic ref_clk, // Core clock, 250 MHz
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic [15:0] instr_word, // Instruction word from fetch
	input wire logic instr_valid, // Word valid, sampled in Q1
	input wire logic [BANK_W-1:0] bank_select_value, // Current bank number
	input wire logic [DATA_W-1:0] file_rd_data, // Read data from file memory
	output logic [FULL_ADDR_W-1:0] file_addr, // Full data address
	output logic file_rd_en, // Read strobe during Q2
	output logic file_wr_en, // Write strobe during Q4
	output logic [DATA_W-1:0] file_wr_data, // Write data during Q4
	output logic [DATA_W-1:0] w_reg, // Working register
	output logic status_wr, // Status flag update strobe
	output logic [3:0] phase, // Current phase, one-hot
	output logic done // Instruction retires, high in Q4
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	rff_phase_t phase_q, phase_d; // Phase sequencer
	rff_op_t op_q, op_d; // Operation being executed
	logic [15:0] ir_q, ir_d; // Captured instruction
	logic [FULL_ADDR_W-1:0] addr_q, addr_d; // Effective address
	logic rd_en_q, rd_en_d; // Read strobe
	logic wr_en_q, wr_en_d; // Write strobe
	logic [DATA_W-1:0] wr_data_q, wr_data_d; // Write data
	logic [DATA_W-1:0] data_q, data_d; // Operand latch
	logic [DATA_W-1:0] w_q, w_d; // Working register
	logic status_q, status_d; // Status update strobe
	logic done_q, done_d; // Retire flag
	rff_op_t dec_op; // Decode of the incoming word

	rff_alu_if alu_bus (); // Link to the data unit

	// ----------------------------------------------------------------
	// Data unit
	// ----------------------------------------------------------------
	assign alu_bus.op = op_q;
	assign alu_bus.src = data_q;

	rff_alu u_alu (
		.bus (alu_bus)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Phases always run so the core keeps a fixed cycle cadence
	always_comb begin
		phase_d = phase_q;
		op_d = op_q;
		ir_d = ir_q;
		addr_d = addr_q;
		rd_en_d = rd_en_q;
		wr_en_d = wr_en_q;
		wr_data_d = wr_data_q;
		data_d = data_q;
		w_d = w_q;
		status_d = status_q;
		done_d = done_q;
		dec_op = rff_decode(instr_word);
		case (phase_q)
			RFF_Q1: begin // Decode
				phase_d = RFF_Q2;
				wr_en_d = 1'b0;
				done_d = 1'b0;
				status_d = 1'b0;
				if (instr_valid) begin
					op_d = dec_op;
					ir_d = instr_word;
					// Offset is taken unsigned, bank from a-bit
					addr_d = rff_eff_addr(instr_word[8], instr_word[7:0],
						bank_select_value);
					rd_en_d = (dec_op != RFF_OP_NONE);
				end else begin
					op_d = RFF_OP_NONE; // Bubble
					rd_en_d = 1'b0;
				end
			end
			RFF_Q2: begin // Read file register
				phase_d = RFF_Q3;
				rd_en_d = 1'b0;
				data_d = file_rd_data;
			end
			RFF_Q3: begin // Process; destination registered for Q4
				phase_d = RFF_Q4;
				if (op_q != RFF_OP_NONE) begin
					done_d = 1'b1; // Retire pulse stands in Q4 only
					status_d = alu_bus.status_we;
					if (op_q == RFF_OP_ROT && !ir_q[9]) begin
						w_d = alu_bus.result;
					end else begin
						// Fill always targets the file register
						wr_en_d = 1'b1;
						wr_data_d = alu_bus.result;
					end
				end
			end
			RFF_Q4: begin // Write destination
				phase_d = RFF_Q1;
				// Drop Q4 strobes here, else they linger into the next decode
				wr_en_d = 1'b0;
				done_d = 1'b0;
				status_d = 1'b0;
			end
			default: begin
				// Illegal code: resynchronise to decode
				phase_d = RFF_Q1;
				wr_en_d = 1'b0;
				rd_en_d = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			phase_q <= RFF_Q1;
			op_q <= RFF_OP_NONE;
			ir_q <= 16'h0000;
			addr_q <= ADDR_RESET;
			rd_en_q <= 1'b0;
			wr_en_q <= 1'b0;
			wr_data_q <= 8'h00;
			data_q <= 8'h00;
			w_q <= W_RESET;
			status_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			op_q <= op_d;
			ir_q <= ir_d;
			addr_q <= addr_d;
			rd_en_q <= rd_en_d;
			wr_en_q <= wr_en_d;
			wr_data_q <= wr_data_d;
			data_q <= data_d;
			w_q <= w_d;
			status_q <= status_d;
			done_q <= done_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, each straight from a flop
	// ----------------------------------------------------------------
	assign file_addr = addr_q;
	assign file_rd_en = rd_en_q;
	assign file_wr_en = wr_en_q;
	assign file_wr_data = wr_data_q;
	assign w_reg = w_q;
	assign status_wr = status_q;
	assign phase = phase_q;
	assign done = done_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	AST_FILL_VALUE: assert property (
		(phase_q == RFF_Q4 && op_q == RFF_OP_FILL) |-> (wr_en_q && wr_data_q == 8'hFF))
		else $error("fill did not write FFh in Q4");

	AST_FILL_DECODE: assert property (
		(phase_q == RFF_Q1 && instr_valid && instr_word[15:9] == 7'b0110100)
		|=> (op_q == RFF_OP_FILL) ##2 (wr_en_q && addr_q[7:0] == ir_q[7:0]))
		else $error("fill word not executed");

	AST_NO_STATUS: assert property (
		(op_q != RFF_OP_NONE) |-> !status_q)
		else $error("status flags written");

	AST_ACCESS_BANK: assert property (
		(phase_q == RFF_Q1 && instr_valid && !instr_word[8])
		|=> addr_q == {($past(instr_word[7]) ? 4'hF : 4'h0), $past(instr_word[7:0])})
		else $error("access bank address wrong");

	AST_BANKED: assert property (
		(phase_q == RFF_Q1 && instr_valid && instr_word[8])
		|=> addr_q == {$past(bank_select_value), $past(instr_word[7:0])})
		else $error("banked address wrong");

	AST_ROTATE: assert property (
		(phase_q == RFF_Q3 && op_q == RFF_OP_ROT && ir_q[9])
		|=> wr_data_q == {$past(data_q[0]), $past(data_q[7:1])})
		else $error("rotate result wrong");

	AST_DEST_W: assert property (
		(phase_q == RFF_Q3 && op_q == RFF_OP_ROT && !ir_q[9])
		|=> (!wr_en_q && w_q == {$past(data_q[0]), $past(data_q[7:1])}))
		else $error("rotate to W misrouted");

	AST_DEST_F: assert property (
		(phase_q == RFF_Q3 && op_q == RFF_OP_ROT && ir_q[9])
		|=> (wr_en_q && $stable(w_q)))
		else $error("rotate to file misrouted");

	AST_FADDR: assert property (
		(phase_q == RFF_Q2 && rd_en_q) |-> (addr_q[7:0] == ir_q[7:0]))
		else $error("file offset not taken from word");

	AST_PHASE: assert property (
		(phase_q == RFF_Q1) |=> (phase_q == RFF_Q2) ##1 (phase_q == RFF_Q3)
		##1 (phase_q == RFF_Q4) ##1 (phase_q == RFF_Q1))
		else $error("phase order broken");

	AST_STROBE_Q4: assert property (
		(wr_en_q || done_q) |-> (phase_q == RFF_Q4))
		else $error("write or retire strobe outside Q4");

endmodule : rff_core

`default_nettype wire

// ### verification/rff_core_tb_top.sv
// Purpose: Self-checking bench for the rotate/fill four-phase datapath
// Assumes: File memory answers combinationally while the read strobe is high
// Notes: Each scenario except sc_stray_valid issues whole instructions and judges every phase

`timescale 1ns/1ps
`default_nettype none

module rff_core_tb_top;
	import rff_pkg::*;

	// ----------------------------------------------------------------
	// Stimulus and observation
	// ----------------------------------------------------------------
	logic ref_clk = 1'b0; // Core clock
	logic reset_n = 1'b0; // Held low at start
	logic [15:0] instr_word = 16'h0000; // Word to core
	logic instr_valid = 1'b0; // Word qualifier
	logic [BANK_W-1:0] bank_select_value = 4'h0; // Bank number
	logic [DATA_W-1:0] rd_val_q = 8'h00; // Byte the file memory holds
	logic [DATA_W-1:0] file_rd_data; // Memory answer
	logic [FULL_ADDR_W-1:0] file_addr; // Observed address
	logic file_rd_en, file_wr_en, status_wr, done; // Observed strobes
	logic [DATA_W-1:0] file_wr_data, w_reg; // Observed data
	logic [3:0] phase; // Observed phase
	int miscompares = 0; // Mismatch count
	int n_compared = 0; // Comparison count

	// Unselected memory shows the inverse, so a stale sample is caught
	assign file_rd_data = file_rd_en ? rd_val_q : ~rd_val_q;

	// Half-period toggle, 4 ns period
	always #2 ref_clk = ~ref_clk;

	rff_core dut (
		.ref_clk(ref_clk), .reset_n(reset_n), .instr_word(instr_word),
		.instr_valid(instr_valid), .bank_select_value(bank_select_value),
		.file_rd_data(file_rd_data), .file_addr(file_addr), .file_rd_en(file_rd_en),
		.file_wr_en(file_wr_en), .file_wr_data(file_wr_data), .w_reg(w_reg),
		.status_wr(status_wr), .phase(phase), .done(done)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	// Verdict in one place
	task automatic tally_and_finish();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish

	// Case-equality compare with report
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Stop at the edge whose pre-edge phase is p; bounded
	task automatic wait_phase(input logic [3:0] p);
		int i;
		i = 0;
		@(posedge ref_clk);
		while (phase !== p && i < 8) begin
			@(posedge ref_clk);
			i++;
		end
		if (i == 8) begin
			miscompares++;
			tally_and_finish();
		end
	endtask : wait_phase

	// One instruction: present in Q1, judge Q2..Q4
	task automatic run_op(input logic [15:0] w, input logic [3:0] bank, input logic [7:0] rd,
		input logic act, input logic [11:0] addr, input logic wr, input logic [7:0] val,
		input logic wupd);
		logic [7:0] w_before;
		wait_phase(4'h8);
		w_before = w_reg;
		instr_word <= w;
		instr_valid <= 1'b1;
		bank_select_value <= bank;
		rd_val_q <= rd;
		#1;
		// Q4 strobes of the previous word must be gone in decode
		chk(file_wr_en | done, 16'h0);
		@(posedge ref_clk);
		// Scramble inputs once taken: later phases must not look at them
		instr_valid <= 1'b0;
		instr_word <= ~w;
		bank_select_value <= ~bank;
		#1;
		chk(phase, 16'h2);
		chk(file_rd_en, act);
		if (act) chk(file_addr, addr);
		@(posedge ref_clk);
		#1;
		chk(phase, 16'h4);
		chk(file_rd_en | file_wr_en, 16'h0);
		@(posedge ref_clk);
		#1;
		chk(phase, 16'h8);
		chk(done, act);
		chk(file_wr_en, wr);
		if (wr) chk(file_wr_data, val);
		chk(w_reg, wupd ? val : w_before);
		chk(status_wr, 16'h0);
	endtask : run_op

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Fill across access halves and banked addressing, back to back
	task automatic sc_fill();
		run_op({FILL_OPC, 1'b0, 8'h5A}, 4'h7, 8'h5A, 1, 12'h05A, 1, 8'hFF, 0);
		run_op({FILL_OPC, 1'b0, 8'h7F}, 4'h7, 8'h00, 1, 12'h07F, 1, 8'hFF, 0);
		run_op({FILL_OPC, 1'b0, 8'h80}, 4'h7, 8'h00, 1, 12'hF80, 1, 8'hFF, 0);
		run_op({FILL_OPC, 1'b1, 8'hFF}, 4'h3, 8'h12, 1, 12'h3FF, 1, 8'hFF, 0);
		run_op({FILL_OPC, 1'b1, 8'h00}, 4'hA, 8'hFF, 1, 12'hA00, 1, 8'hFF, 0);
	endtask : sc_fill

	// Rotate into the working register, file left alone
	task automatic sc_rot_w();
		run_op({ROT_OPC, 2'b00, 8'h34}, 4'h5, 8'hD7, 1, 12'h034, 0, 8'hEB, 1);
		run_op({ROT_OPC, 2'b00, 8'h81}, 4'h5, 8'h80, 1, 12'hF81, 0, 8'h40, 1);
	endtask : sc_rot_w

	// Rotate written back; bit 0 must wrap to bit 7
	task automatic sc_rot_file();
		run_op({ROT_OPC, 2'b11, 8'h12}, 4'h2, 8'hD7, 1, 12'h212, 1, 8'hEB, 0);
		run_op({ROT_OPC, 2'b10, 8'hFE}, 4'h9, 8'h01, 1, 12'hFFE, 1, 8'h80, 0);
	endtask : sc_rot_file

	// Near-miss opcodes act as bubbles
	task automatic sc_bubble();
		run_op(16'h6A5A, 4'h1, 8'h00, 0, 12'h000, 0, 8'h00, 0);
		run_op(16'h4412, 4'h1, 8'h00, 0, 12'h000, 0, 8'h00, 0);
	endtask : sc_bubble

	// Valid raised only in Q2..Q4 is ignored; dropped again before decode
	task automatic sc_stray_valid();
		wait_phase(4'h1);
		instr_word <= {FILL_OPC, 1'b1, 8'h33};
		instr_valid <= 1'b1;
		repeat (2) begin
			@(posedge ref_clk);
			#1;
			chk(file_wr_en | done, 16'h0);
		end
		// Edge entering Q1: valid must be low for the whole decode phase
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		#1;
		chk(phase, 16'h1);
		@(posedge ref_clk);
		#1;
		chk(file_rd_en, 16'h0);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(file_wr_en | done, 16'h0);
	endtask : sc_stray_valid

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		#1;
		chk(phase, 16'h1);
		chk(w_reg, 16'h0);
		chk(done, 16'h0);
		sc_fill();
		sc_rot_w();
		sc_rot_file();
		sc_bubble();
		sc_stray_valid();
		tally_and_finish();
	end

endmodule : rff_core_tb_top

`default_nettype wire
